// ---- bench/eeprom_autoload_sequencer_sva.sv ----
// Port checker for the autoload sequencer
`timescale 1ns/10ps
module eeprom_autoload_sequencer_chk #(
   parameter int QUARTER = 2
) (
   input wire logic sys_clk,             // Core clock
   input wire logic reset_n,             // Synchronous reset
   input wire logic upstream_reset_n,    // Upstream reset
   input wire logic wb_cyc_i,            // Bus cycle
   input wire logic wb_stb_i,            // Bus strobe
   input wire logic wb_we_i,             // Bus write
   input wire logic [7:0] wb_adr_i,      // Byte address
   input wire logic [31:0] wb_dat_o,     // Read data
   input wire logic wb_ack_o,            // Acknowledge
   input wire logic nvm_serial_clock,    // Memory clock
   input wire logic nvm_serial_data_out, // Data value
   input wire logic nvm_serial_data_oe   // Data enable
);
   default clocking cb @(posedge sys_clk);
   endclocking
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_pulse;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   property p_ack_resp;
      disable iff (!reset_n) s_req |=> s_pulse;
   endproperty
   a_ack_resp: assert property (p_ack_resp) else $error("ack not a single pulse");
   property p_ack_cause;
      disable iff (!reset_n) wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i);
   endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
   property p_out_zero;
      disable iff (!reset_n) nvm_serial_data_out == 1'b0;
   endproperty
   a_out_zero: assert property (p_out_zero) else $error("data driven high");
   property p_clk_low;
      disable iff (!reset_n) $fell(nvm_serial_clock) |=> !nvm_serial_clock;
   endproperty
   a_clk_low: assert property (p_clk_low) else $error("clock low too short");
   property p_clk_high;
      disable iff (!reset_n) $rose(nvm_serial_clock) |=> nvm_serial_clock;
   endproperty
   a_clk_high: assert property (p_clk_high) else $error("clock high too short");
   property p_hold_up;
      disable iff (!reset_n)
         !upstream_reset_n [*4] |-> nvm_serial_clock && !nvm_serial_data_oe;
   endproperty
   a_hold_up: assert property (p_hold_up) else $error("link busy in reset");
   property p_unmapped;
      disable iff (!reset_n)
         wb_ack_o && !wb_we_i && wb_adr_i == 8'h40 |-> wb_dat_o == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_reset_quiet;
      !reset_n ##1 !reset_n |-> !wb_ack_o && !nvm_serial_data_oe && nvm_serial_clock;
   endproperty
   a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active in reset");
endmodule
bind eeprom_autoload_sequencer eeprom_autoload_sequencer_chk #(.QUARTER(QUARTER)) chk (
   .sys_clk(sys_clk), .reset_n(reset_n), .upstream_reset_n(upstream_reset_n),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .nvm_serial_clock(nvm_serial_clock),
   .nvm_serial_data_out(nvm_serial_data_out), .nvm_serial_data_oe(nvm_serial_data_oe));

// ---- bench/nvm_memory_model.sv ----
// Behavioural two-wire serial memory, 256 bytes, straps at zero
`timescale 1ns/10ps
module nvm_memory_model (
   input wire logic scl,     // Serial clock
   input wire logic sda,     // Data wire level
   input wire logic present, // Low: part ignores its select code
   output logic pullLow      // Pulls the data wire low
);
   localparam logic [6:0] SELECT = 7'h50;
   logic [7:0] mem [0:255];
   logic [7:0] sh, cur, ptr;
   logic rd = 1'b0;
   int cnt = 9;
   int nb;
   initial pullLow = 1'b0;
   // Start restarts the frame, stop ends it
   always @(sda)
      if (scl === 1'b1)
      begin
         cnt = sda ? 9 : -1;
         nb = -1;
         rd = 1'b0;
      end
   always @(posedge scl)
      if (cnt >= 0 && cnt < 8)
         sh = {sh[6:0], sda};
      else if (cnt == 8 && rd && sda)
         rd = 1'b0;
   always @(negedge scl)
      if (cnt < 9)
      begin
         cnt = (cnt + 1) % 9;
         if (cnt == 0)
         begin
            nb++;
            cur = mem[ptr];
            if (rd)
               ptr++;
         end
         if (cnt == 8 && !rd)
         begin
            if (nb == 0)
               rd = sh[0];
            else if (nb == 1)
               ptr = sh;
            else
            begin
               mem[ptr] = sh;
               ptr++;
            end
            pullLow <= present && (nb > 0 || sh[7:1] == SELECT);
         end
         else
            pullLow <= rd && cnt < 8 && !cur[7 - cnt];
      end
endmodule

// ---- bench/test_eeprom_autoload_sequencer.sv ----
// Self-checking bench for the autoload sequencer
`timescale 1ns/10ps
module test_eeprom_autoload_sequencer;
   import nvm_loader_pkg::*;
   logic sys_clk = 1'b0, reset_n = 1'b0, upRstN = 1'b0, present = 1'b1;
   logic wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, wbAck, irq, sclk, sdOut, sdOe, pullLow;
   logic [7:0] wbAdr = 8'h00;
   logic [31:0] wbDat = 32'h0, wbDatO, q;
   logic [15:0] w [0:127];
   logic [6:0] a;
   logic [15:0] d;
   int nErrors = 0, comparisons = 0;
   wire sdWire = !(sdOe || pullLow);
   always #5 sys_clk = ~sys_clk;
   eeprom_autoload_sequencer #(.QUARTER(2)) uut (.sys_clk(sys_clk), .reset_n(reset_n),
      .upstream_reset_n(upRstN), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
      .wb_adr_i(wbAdr), .wb_sel_i(4'hf), .wb_dat_i(wbDat), .wb_dat_o(wbDatO),
      .wb_ack_o(wbAck), .nvm_serial_clock(sclk), .nvm_serial_data_in(sdWire),
      .nvm_serial_data_out(sdOut), .nvm_serial_data_oe(sdOe), .irq(irq));
   nvm_memory_model memory (.scl(sclk), .sda(sdWire), .present(present), .pullLow(pullLow));
   task automatic report_and_stop();
      $display("errors %0d comparisons %0d", nErrors, comparisons);
      if (nErrors == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp)
      begin
         nErrors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
      int n;
      n = 0;
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= we;
      wbAdr <= adr;
      wbDat <= dat;
      do
      begin
         @(posedge sys_clk);
         n++;
      end
      while (wbAck !== 1'b1 && n < 20);
      chk("ack", 32'h1, {31'h0, wbAck});
      q = wbDatO;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic waitBit(input int b);
      int n;
      n = 0;
      do
      begin
         wb(1'b0, REG_STATUS, 32'h0);
         n++;
      end
      while (q[b] !== 1'b0 && n < 5000);
      chk("status", 32'h0, {31'h0, q[b]});
   endtask
   function automatic logic [31:0] expReg(input int r, input logic bad);
      if (bad)
         return (r == 0) ? {DEF_DEVICE, DEF_VENDOR} : {DEF_ZERO, DEF_ZERO};
      case (r)
         0: return {w[2], w[1]};
         1: return {w[5], w[4]};
         2: return {16'h0, w[3]};
         3: return {16'h0, w[6]};
         4: return {16'h0, w[7]};
         default: return {16'h0, w[r + 11]};
      endcase
   endfunction
   task automatic boot(input logic [15:0] sig);
      for (int i = 0; i < 128; i++)
      begin
         w[i] = (i == 0) ? sig : 16'($urandom);
         memory.mem[2 * i] = w[i][7:0];
         memory.mem[2 * i + 1] = w[i][15:8];
      end
      reset_n <= 1'b0;
      upRstN <= 1'b0;
      repeat (6) @(posedge sys_clk);
      reset_n <= 1'b1;
      repeat (10) @(posedge sys_clk);
      wb(1'b0, REG_STATUS, 32'h0);
      chk("flag", 32'h1, {31'h0, q[STAT_AUTOLOAD_BIT]});
      upRstN <= 1'b1;
      waitBit(STAT_AUTOLOAD_BIT);
   endtask
   task automatic checkRegs(input logic bad);
      for (int r = 0; r < 8; r++)
      begin
         wb(1'b0, 8'(4 * r), 32'h0);
         chk("loaded", expReg(r, bad), q);
      end
   endtask
   initial
   begin
      void'($urandom(32'hca74));
      boot(SIGNATURE);
      checkRegs(1'b0);
      wb(1'b1, REG_ID, 32'hffffffff);
      wb(1'b0, REG_ID, 32'h0);
      chk("readonly", expReg(0, 1'b0), q);
      wb(1'b0, 8'h40, 32'h0);
      chk("unmapped", 32'h0, q);
      // Autoload event: masked, then raised, then cleared
      chk("irq", 32'h0, {31'h0, irq});
      wb(1'b1, REG_IRQ_MASK, 32'h7);
      chk("irq", 32'h1, {31'h0, irq});
      wb(1'b1, REG_IRQ_STAT, 32'h1);
      chk("irq", 32'h0, {31'h0, irq});
      for (int k = 0; k < 6; k++)
      begin
         a = (k == 0) ? 7'h7f : 7'($urandom);
         d = 16'($urandom);
         wb(1'b1, REG_NVM_DATA, {16'h0, d});
         wb(1'b1, REG_NVM_CTRL, {17'h0, a, 8'h03});
         waitBit(STAT_BUSY_BIT);
         chk("stored", {16'h0, d}, {memory.mem[2 * a + 1], memory.mem[2 * a]});
         wb(1'b1, REG_NVM_CTRL, {17'h0, a, 8'h01});
         waitBit(STAT_BUSY_BIT);
         wb(1'b0, REG_NVM_DATA, 32'h0);
         chk("readback", {16'h0, d}, {16'h0, q[31:16]});
      end
      chk("irq", 32'h1, {31'h0, irq});
      wb(1'b1, REG_IRQ_STAT, 32'h7);
      // A part that ignores its select code must be reported
      present <= 1'b0;
      wb(1'b1, REG_NVM_CTRL, 32'h00000101);
      waitBit(STAT_BUSY_BIT);
      chk("nack", 32'h1, {31'h0, q[STAT_NACK_BIT]});
      wb(1'b0, REG_IRQ_STAT, 32'h0);
      chk("irqstat", 32'h6, q & 32'h7);
      present <= 1'b1;
      boot(~SIGNATURE);
      checkRegs(1'b1);
      report_and_stop();
   end
   initial
   begin
      #1000000;
      nErrors++;
      report_and_stop();
   end
endmodule

// ---- src/eeprom_autoload_sequencer.sv ----
// Serial memory autoload sequencer with software word access over Wishbone
`timescale 1ns/10ps
module eeprom_autoload_sequencer #(
   parameter int QUARTER = nvm_loader_pkg::QUARTER_CYCLES
) (
   input wire logic sys_clk,                              // Core clock
   input wire logic reset_n,                              // Synchronous reset
   input wire logic upstream_reset_n,                     // Upstream reset pin
   input wire logic wb_cyc_i,                             // Bus cycle
   input wire logic wb_stb_i,                             // Bus strobe
   input wire logic wb_we_i,                              // Bus write
   input wire logic [nvm_loader_pkg::ADDR_W-1:0] wb_adr_i, // Byte address
   input wire logic [3:0] wb_sel_i,                       // Byte lanes
   input wire logic [31:0] wb_dat_i,                      // Write data
   output logic [31:0] wb_dat_o,                          // Read data
   output logic wb_ack_o,                                 // Bus acknowledge
   output wire logic nvm_serial_clock,                    // Memory clock
   input wire logic nvm_serial_data_in,                   // Memory data level
   output wire logic nvm_serial_data_out,                 // Memory data value
   output wire logic nvm_serial_data_oe,                  // Memory data enable
   output logic irq                                       // Interrupt level
);
   import nvm_loader_pkg::*;
   typedef enum logic [4:0] {
      S_HOLD = 5'b00001,
      S_SIG = 5'b00010,
      S_LOAD = 5'b00100,
      S_IDLE = 5'b01000,
      S_SW = 5'b10000
   } seq_t;

   nvm_word_if word ();

   seq_t state_r;
   logic upMeta_r, upSync_r;
   logic [15:0] vendorId_r, deviceId_r, subVendor_r, subsys_r;
   logic [15:0] portCfg_r, capCfg_r, txMargin_r;
   logic [15:0] phy_r [0:2];
   logic autoloadBusy_r;
   logic [6:0] wordIdx_r;
   logic start_r, reqWrite_r;
   logic [6:0] reqAddr_r;
   logic [15:0] reqData_r;
   logic ctrlWrite_r;
   logic [6:0] ctrlAddr_r;
   logic [15:0] dataOut_r, dataIn_r;
   logic swNack_r;
   logic [IRQ_W-1:0] irqStat_r, irqMask_r, irqEv;
   logic acc, wrAcc, swStart, loadWe, loadEnd;
   logic [7:0] loadOff;
   logic [31:0] rdMux, statWord;

   function automatic logic [31:0] laneMerge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] sel);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++)
         if (sel[i])
            res[i*8 +: 8] = nw[i*8 +: 8];
      laneMerge = res;
   endfunction

   nvm_serial_engine #(
      .QUARTER(QUARTER)
   ) u_engine (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .bus(word.engine),
      .sclOut(nvm_serial_clock),
      .sdaIn(nvm_serial_data_in),
      .sdaOut(nvm_serial_data_out),
      .sdaOe(nvm_serial_data_oe)
   );

   assign word.start = start_r;
   assign word.write = reqWrite_r;
   assign word.wordAddr = reqAddr_r;
   assign word.wdata = reqData_r;

   // Upstream reset pin synchroniser
   always_ff @(posedge sys_clk)
   begin
      upMeta_r <= upstream_reset_n;
      upSync_r <= upMeta_r;
   end

   assign acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wrAcc = acc && wb_we_i;
   assign swStart = wrAcc && wb_adr_i == REG_NVM_CTRL && wb_sel_i[0]
                    && wb_dat_i[CTRL_START_BIT];
   assign loadWe = state_r == S_LOAD && word.done;
   assign loadOff = {wordIdx_r, 1'b0};
   assign loadEnd = (state_r == S_LOAD && word.done && wordIdx_r == EE_LAST_WORD)
                    || (state_r == S_SIG && word.done
                        && (word.nack || word.rdata != SIGNATURE));

   // Autoload and software access sequencer
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         state_r <= S_HOLD;
         autoloadBusy_r <= 1'b1;
         wordIdx_r <= 7'h00;
         start_r <= 1'b0;
         reqWrite_r <= 1'b0;
         reqAddr_r <= 7'h00;
         reqData_r <= 16'h0000;
      end
      else if (!upSync_r)
      begin
         state_r <= S_HOLD;
         autoloadBusy_r <= 1'b1;
         start_r <= 1'b0;
      end
      else
      begin
         start_r <= 1'b0;
         case (state_r)
            S_HOLD:
               if (word.idle && !start_r)
               begin
                  state_r <= S_SIG;
                  reqWrite_r <= 1'b0;
                  reqAddr_r <= 7'h00;
                  start_r <= 1'b1;
               end
            S_SIG:
               if (word.done)
               begin
                  if (!word.nack && word.rdata == SIGNATURE)
                  begin
                     state_r <= S_LOAD;
                     wordIdx_r <= 7'h01;
                     reqAddr_r <= 7'h01;
                     start_r <= 1'b1;
                  end
                  else
                  begin
                     state_r <= S_IDLE;
                     autoloadBusy_r <= 1'b0;
                  end
               end
            S_LOAD:
               if (word.done)
               begin
                  if (wordIdx_r == EE_LAST_WORD)
                  begin
                     state_r <= S_IDLE;
                     autoloadBusy_r <= 1'b0;
                  end
                  else
                  begin
                     wordIdx_r <= wordIdx_r + 7'h01;
                     reqAddr_r <= wordIdx_r + 7'h01;
                     start_r <= 1'b1;
                  end
               end
            S_IDLE:
               if (swStart)
               begin
                  state_r <= S_SW;
                  reqWrite_r <= wb_dat_i[CTRL_WRITE_BIT];
                  reqAddr_r <= wb_sel_i[1] ? wb_dat_i[CTRL_ADDR_LSB +: 7] : ctrlAddr_r;
                  reqData_r <= dataOut_r;
                  start_r <= 1'b1;
               end
            S_SW:
               if (word.done)
                  state_r <= S_IDLE;
            default: state_r <= S_HOLD;
         endcase
      end
   end

   // Registers filled by the autoload; defaults return with upstream reset
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n || !upSync_r)
      begin
         vendorId_r <= DEF_VENDOR;
         deviceId_r <= DEF_DEVICE;
         subVendor_r <= DEF_ZERO;
         subsys_r <= DEF_ZERO;
         portCfg_r <= DEF_ZERO;
         capCfg_r <= DEF_ZERO;
         txMargin_r <= DEF_ZERO;
         for (int i = 0; i < 3; i++)
            phy_r[i] <= DEF_ZERO;
      end
      else if (loadWe && !word.nack)
      begin
         case (loadOff)
            EE_VENDOR: vendorId_r <= word.rdata;
            EE_DEVICE: deviceId_r <= word.rdata;
            EE_PORTCFG: portCfg_r <= word.rdata;
            EE_SUBVEN: subVendor_r <= word.rdata;
            EE_SUBSYS: subsys_r <= word.rdata;
            EE_CAPCFG: capCfg_r <= word.rdata;
            EE_TXMARGIN: txMargin_r <= word.rdata;
            EE_PHY0: phy_r[0] <= word.rdata;
            EE_PHY1: phy_r[1] <= word.rdata;
            EE_PHY2: phy_r[2] <= word.rdata;
            default: vendorId_r <= vendorId_r;
         endcase
      end
   end

   // Software access control and data registers
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         ctrlWrite_r <= 1'b0;
         ctrlAddr_r <= 7'h00;
         dataOut_r <= 16'h0000;
      end
      else if (wrAcc)
      begin
         if (wb_adr_i == REG_NVM_CTRL && wb_sel_i[0])
            ctrlWrite_r <= wb_dat_i[CTRL_WRITE_BIT];
         if (wb_adr_i == REG_NVM_CTRL && wb_sel_i[1])
            ctrlAddr_r <= wb_dat_i[CTRL_ADDR_LSB +: 7];
         if (wb_adr_i == REG_NVM_DATA)
            dataOut_r <= 16'(laneMerge({16'h0000, dataOut_r}, wb_dat_i, wb_sel_i));
      end
   end

   // Result of the last software access
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         dataIn_r <= 16'h0000;
         swNack_r <= 1'b0;
      end
      else if (state_r == S_SW && word.done)
      begin
         swNack_r <= word.nack;
         if (!reqWrite_r)
            dataIn_r <= word.rdata;
      end
   end

   always_comb
   begin
      irqEv = '0;
      irqEv[IRQ_LOADED] = loadEnd;
      irqEv[IRQ_ACCESS] = state_r == S_SW && word.done;
      irqEv[IRQ_NACK] = word.done && word.nack;
   end

   // Sticky events; a new event wins over a write-one clear
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
         irqStat_r <= '0;
      else if (wrAcc && wb_adr_i == REG_IRQ_STAT && wb_sel_i[0])
         irqStat_r <= (irqStat_r & ~wb_dat_i[IRQ_W-1:0]) | irqEv;
      else
         irqStat_r <= irqStat_r | irqEv;
   end

   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
         irqMask_r <= '0;
      else if (wrAcc && wb_adr_i == REG_IRQ_MASK && wb_sel_i[0])
         irqMask_r <= wb_dat_i[IRQ_W-1:0];
   end

   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
         irq <= 1'b0;
      else
         irq <= |(irqStat_r & irqMask_r);
   end

   always_comb
   begin
      statWord = 32'h0000_0000;
      statWord[STAT_BUSY_BIT] = state_r == S_SW;
      statWord[STAT_NACK_BIT] = swNack_r;
      statWord[STAT_AUTOLOAD_BIT] = autoloadBusy_r;
   end

   always_comb
   begin
      case (wb_adr_i)
         REG_ID: rdMux = {deviceId_r, vendorId_r};
         REG_SUBSYS: rdMux = {subsys_r, subVendor_r};
         REG_PORTCFG: rdMux = {16'h0000, portCfg_r};
         REG_CAPCFG: rdMux = {16'h0000, capCfg_r};
         REG_TXMARGIN: rdMux = {16'h0000, txMargin_r};
         REG_PHY0: rdMux = {16'h0000, phy_r[0]};
         REG_PHY1: rdMux = {16'h0000, phy_r[1]};
         REG_PHY2: rdMux = {16'h0000, phy_r[2]};
         REG_NVM_CTRL: rdMux = {17'h00000, ctrlAddr_r, 6'h00, ctrlWrite_r, 1'b0};
         REG_STATUS: rdMux = statWord;
         REG_NVM_DATA: rdMux = {dataIn_r, dataOut_r};
         REG_IRQ_STAT: rdMux = {29'h00000000, irqStat_r};
         REG_IRQ_MASK: rdMux = {29'h00000000, irqMask_r};
         default: rdMux = 32'h0000_0000;
      endcase
   end

   // Bus slave answers every access one cycle after it is taken
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end
      else
      begin
         wb_ack_o <= acc;
         if (acc && !wb_we_i)
            wb_dat_o <= rdMux;
      end
   end
endmodule

// ---- src/nvm_loader_pkg.sv ----
// Constants shared by the serial memory loader and its bit engine
package nvm_loader_pkg;
   localparam int CLK_PERIOD_NS = 10;
   localparam int NVM_CLK_PERIOD_NS = 2500;
   localparam int QUARTER_CYCLES =
      (NVM_CLK_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);
   localparam int WORD_ADDR_W = 7;
   localparam int WORD_W = 16;
   localparam int ADDR_W = 8;
   localparam logic [7:0] CTRL_WR = 8'ha0;
   localparam logic [7:0] CTRL_RD = 8'ha1;
   localparam logic [15:0] SIGNATURE = 16'h1516;
   localparam logic [7:0] EE_VENDOR = 8'h02;
   localparam logic [7:0] EE_DEVICE = 8'h04;
   localparam logic [7:0] EE_PORTCFG = 8'h06;
   localparam logic [7:0] EE_SUBVEN = 8'h08;
   localparam logic [7:0] EE_SUBSYS = 8'h0a;
   localparam logic [7:0] EE_CAPCFG = 8'h0c;
   localparam logic [7:0] EE_TXMARGIN = 8'h0e;
   localparam logic [7:0] EE_PHY0 = 8'h20;
   localparam logic [7:0] EE_PHY1 = 8'h22;
   localparam logic [7:0] EE_PHY2 = 8'h24;
   localparam logic [6:0] EE_LAST_WORD = 7'h12;
   localparam logic [7:0] REG_ID = 8'h00;
   localparam logic [7:0] REG_SUBSYS = 8'h04;
   localparam logic [7:0] REG_PORTCFG = 8'h08;
   localparam logic [7:0] REG_CAPCFG = 8'h0c;
   localparam logic [7:0] REG_TXMARGIN = 8'h10;
   localparam logic [7:0] REG_PHY0 = 8'h14;
   localparam logic [7:0] REG_PHY1 = 8'h18;
   localparam logic [7:0] REG_PHY2 = 8'h1c;
   localparam logic [7:0] REG_NVM_CTRL = 8'hd8;
   localparam logic [7:0] REG_STATUS = 8'hdc;
   localparam logic [7:0] REG_NVM_DATA = 8'he0;
   localparam logic [7:0] REG_IRQ_STAT = 8'he4;
   localparam logic [7:0] REG_IRQ_MASK = 8'he8;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_NACK_BIT = 1;
   localparam int STAT_AUTOLOAD_BIT = 3;
   localparam int CTRL_START_BIT = 0;
   localparam int CTRL_WRITE_BIT = 1;
   localparam int CTRL_ADDR_LSB = 8;
   localparam int IRQ_W = 3;
   localparam int IRQ_LOADED = 0;
   localparam int IRQ_ACCESS = 1;
   localparam int IRQ_NACK = 2;
   // Identity defaults are arbitrary
   localparam logic [15:0] DEF_VENDOR = 16'h0a5a;
   localparam logic [15:0] DEF_DEVICE = 16'h0b5b;
   localparam logic [15:0] DEF_ZERO = 16'h0000;
endpackage

// ---- src/nvm_serial_engine.sv ----
// Two-wire serial engine moving one 16-bit word to or from the memory
`timescale 1ns/10ps
module nvm_serial_engine #(
   parameter int QUARTER = nvm_loader_pkg::QUARTER_CYCLES
) (
   input wire logic sys_clk,        // Core clock
   input wire logic reset_n,        // Synchronous reset
   nvm_word_if.engine bus,          // Word requests
   output logic sclOut,             // Serial clock pin
   input wire logic sdaIn,          // Serial data pin level
   output logic sdaOut,             // Serial data drive value
   output logic sdaOe               // Serial data drive enable
);
   import nvm_loader_pkg::*;
   typedef enum logic [3:0] {
      E_IDLE = 4'b0001, E_START = 4'b0010, E_BITS = 4'b0100, E_STOP = 4'b1000
   } eng_t;
   eng_t state_r;
   logic [15:0] divCnt_r;
   logic tick;
   logic [1:0] ph_r;
   logic [3:0] bitIdx_r;
   logic [2:0] byteIdx_r;
   logic [7:0] shift_r;
   logic sdaMeta_r, sdaSync_r;
   logic [15:0] rx_r;
   logic nack_r, done_r;
   logic rxByte, lastByte;

   if (QUARTER < 2 || QUARTER > 65535) begin : g_chk
      $error("QUARTER out of range");
   end

   function automatic logic [7:0] txFor(input logic [2:0] idx);
      case (idx)
         3'h0: txFor = CTRL_WR;
         3'h1: txFor = {bus.wordAddr, 1'b0};
         3'h2: txFor = bus.write ? bus.wdata[7:0] : CTRL_RD;
         default: txFor = bus.wdata[15:8];
      endcase
   endfunction

   assign rxByte = !bus.write && byteIdx_r >= 3'h3;
   assign lastByte = bus.write ? byteIdx_r == 3'h3 : byteIdx_r == 3'h4;
   assign tick = divCnt_r == 16'(QUARTER - 1);
   assign bus.rdata = rx_r;
   assign bus.nack = nack_r;
   assign bus.done = done_r;
   assign bus.idle = state_r == E_IDLE;

   always_ff @(posedge sys_clk)
   begin
      sdaMeta_r <= sdaIn;
      sdaSync_r <= sdaMeta_r;
   end

   // Quarter-bit enable
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n || state_r == E_IDLE || tick)
         divCnt_r <= 16'h0000;
      else
         divCnt_r <= divCnt_r + 16'h0001;
   end

   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         state_r <= E_IDLE;
         sclOut <= 1'b1;
         sdaOut <= 1'b0;
         sdaOe <= 1'b0;
         ph_r <= 2'h0;
         bitIdx_r <= 4'h0;
         byteIdx_r <= 3'h0;
         shift_r <= 8'h00;
         rx_r <= 16'h0000;
         nack_r <= 1'b0;
         done_r <= 1'b0;
      end
      else
      begin
         done_r <= 1'b0;
         case (state_r)
            E_IDLE:
            begin
               sclOut <= 1'b1;
               sdaOe <= 1'b0;
               if (bus.start)
               begin
                  state_r <= E_START;
                  ph_r <= 2'h0;
                  byteIdx_r <= 3'h0;
                  nack_r <= 1'b0;
               end
            end
            E_START:
               if (tick)
               begin
                  ph_r <= ph_r + 2'h1;
                  case (ph_r)
                     2'h0:
                     begin
                        sdaOe <= 1'b0;
                        sclOut <= 1'b0;
                     end
                     2'h1: sclOut <= 1'b1;
                     2'h2: sdaOe <= 1'b1;
                     default:
                     begin
                        sclOut <= 1'b0;
                        state_r <= E_BITS;
                        bitIdx_r <= 4'h0;
                        shift_r <= txFor(byteIdx_r);
                     end
                  endcase
               end
            E_BITS:
               if (tick)
               begin
                  ph_r <= ph_r + 2'h1;
                  case (ph_r)
                     2'h0:
                     begin
                        sclOut <= 1'b0;
                        if (bitIdx_r < 4'h8)
                           sdaOe <= !rxByte && !shift_r[7];
                        else
                           sdaOe <= rxByte && byteIdx_r == 3'h3;
                     end
                     2'h1: sclOut <= 1'b1;
                     2'h2:
                        if (bitIdx_r < 4'h8)
                           shift_r <= {shift_r[6:0], sdaSync_r};
                        else if (!rxByte && sdaSync_r)
                           nack_r <= 1'b1;
                     default:
                     begin
                        sclOut <= 1'b0;
                        if (bitIdx_r != 4'h8)
                           bitIdx_r <= bitIdx_r + 4'h1;
                        else
                        begin
                           if (rxByte && byteIdx_r == 3'h3)
                              rx_r[7:0] <= shift_r;
                           if (rxByte && byteIdx_r == 3'h4)
                              rx_r[15:8] <= shift_r;
                           bitIdx_r <= 4'h0;
                           byteIdx_r <= byteIdx_r + 3'h1;
                           shift_r <= txFor(byteIdx_r + 3'h1);
                           if (nack_r || lastByte)
                              state_r <= E_STOP;
                           else if (!bus.write && byteIdx_r == 3'h1)
                              state_r <= E_START;
                        end
                     end
                  endcase
               end
            E_STOP:
               if (tick)
               begin
                  ph_r <= ph_r + 2'h1;
                  case (ph_r)
                     2'h0:
                     begin
                        sclOut <= 1'b0;
                        sdaOe <= 1'b1;
                     end
                     2'h1: sclOut <= 1'b1;
                     2'h2: sdaOe <= 1'b0;
                     default:
                     begin
                        state_r <= E_IDLE;
                        done_r <= 1'b1;
                     end
                  endcase
               end
            default: state_r <= E_IDLE;
         endcase
      end
   end
endmodule

// ---- src/nvm_word_if.sv ----
// Word request carrier between the loader and the serial bit engine
`timescale 1ns/10ps
interface nvm_word_if;
   logic start;
   logic write;
   logic [6:0] wordAddr;
   logic [15:0] wdata;
   logic [15:0] rdata;
   logic done;
   logic nack;
   logic idle;
   modport master (output start, write, wordAddr, wdata, input rdata, done, nack, idle);
   modport engine (input start, write, wordAddr, wdata, output rdata, done, nack, idle);
endinterface
